// file: common/energy_pkg.sv
package energy_pkg;
  localparam int SAMPLE_W = 17;
  localparam int RESULT_W = 16;
  localparam int BUS_MSB_W = 14;
  localparam int POWER_W = 30;
  localparam int ACC_W = 56;
  localparam int COUNT_W = 32;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int MAX_SHIFT = 7;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_SAMPLE = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_ACC_LO = 6'h0c;
  localparam logic [ADDR_W-1:0] OFS_ACC_HI = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_RESULTS = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_CLEAR = 6'h1c;
  // Control field positions
  localparam int CTL_RATE = 0;
  localparam int CTL_ADAPT_N = 2;
  localparam int CTL_SLOW_REFRESH = 3;
  localparam int CTL_BUS_SIGNED = 4;
  localparam int CTL_SENSE_SIGNED = 5;
  localparam int CTL_BUS_HALF = 6;
  localparam int CTL_SENSE_HALF = 7;
  localparam int CTL_SRC = 8;
  localparam int CTL_LIMIT = 10;
  localparam logic [DATA_W-1:0] CONTROL_RESET = 32'h0000_0000;
  // Sample register fields: bus in low half, sense in upper half
  localparam int SMP_SENSE = 16;
  // Status fields
  localparam int ST_BIPOLAR = 0;
  localparam int ST_ACC_LIMIT = 1;
  localparam int ST_CNT_LIMIT = 2;
  localparam int ST_SAT = 3;
  localparam int ST_REFRESH = 4;
  localparam int ST_SLOW = 5;
  localparam int ST_FS_SHIFT = 8;
  localparam logic [4:0] FS_BIPOLAR_LOG2 = 5'h1d;
  localparam logic [4:0] FS_UNIPOLAR_LOG2 = 5'h1e;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [1:0] {RATE_1024, RATE_256, RATE_64, RATE_8} rate_t;
  typedef enum logic [1:0] {SRC_POWER, SRC_SENSE, SRC_BUS, SRC_RSVD} acc_src_t;
  typedef enum logic [1:0] {LIM_FULL, LIM_15_16, LIM_7_8, LIM_3_4} limit_t;

  typedef struct packed {
    logic signed [SAMPLE_W-1:0] bus;
    logic signed [SAMPLE_W-1:0] sense;
  } sample_pair_t;

  typedef struct packed {
    rate_t rate;
    logic adaptive_off;
    logic slow_refresh;
    logic bus_signed;
    logic sense_signed;
    logic bus_half;
    logic sense_half;
    acc_src_t src;
    limit_t limit;
  } control_t;
endpackage

// file: verilog/energy_datapath.sv
`timescale 1ns/100ps
`default_nettype none
// Multiplies, scales and sign-extends one sample into an accumulator addend
module energy_datapath
  import energy_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic in_valid,
  input wire sample_pair_t in_pair,
  input wire acc_src_t src,
  input wire logic [2:0] shift,
  output logic out_valid,
  output logic signed [ACC_W-1:0] addend
);
  wire logic signed [BUS_MSB_W-1:0] bus_msbs = in_pair.bus[SAMPLE_W-1 -: BUS_MSB_W];
  wire logic signed [POWER_W-1:0] power_product = in_pair.sense * bus_msbs;
  wire logic signed [POWER_W-1:0] sense_ext = POWER_W'(in_pair.sense);
  wire logic signed [POWER_W-1:0] bus_ext = POWER_W'(in_pair.bus);
  wire logic signed [POWER_W-1:0] chosen = (src == SRC_SENSE) ? sense_ext :
    (src == SRC_BUS) ? bus_ext : power_product;
  wire logic signed [ACC_W-1:0] widened = ACC_W'(chosen);
  wire logic signed [ACC_W-1:0] next_addend = widened <<< shift;

  // Registered addend stage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_valid <= 1'b0;
      addend <= '0;
    end
    else if (clk_en)
    begin
      out_valid <= in_valid;
      addend <= next_addend;
    end
  end
endmodule
`default_nettype wire

// file: verilog/energy_accumulator_top.sv
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
// Energy accumulator with AXI4-Lite register access
module energy_accumulator_top
  import energy_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic slow_pin,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic refresh_pulse
);
  localparam logic signed [ACC_W-1:0] ACC_MAX = {1'b0, {(ACC_W-1){1'b1}}};
  localparam logic signed [ACC_W-1:0] ACC_MIN = {1'b1, {(ACC_W-1){1'b0}}};

  logic [DATA_W-1:0] control;
  logic [DATA_W-1:0] sample_reg;
  logic sample_strobe;
  logic signed [ACC_W-1:0] energy_accumulator;
  logic [COUNT_W-1:0] count;
  logic saturated;
  logic [2:0] slow_sync;
  logic slow_level;
  logic refresh_seen;
  logic clear_hit;
  logic [COUNT_W-1:0] pend_inc;
  logic [RESULT_W-1:0] bus_voltage_sample;
  logic [RESULT_W-1:0] sense_voltage_sample;

  // Control fields; zero reset value selects adaptive mode and no slow refresh
  wire control_t ctl = '{
    rate: rate_t'(control[CTL_RATE +: 2]),
    adaptive_off: control[CTL_ADAPT_N],
    slow_refresh: control[CTL_SLOW_REFRESH],
    bus_signed: control[CTL_BUS_SIGNED],
    sense_signed: control[CTL_SENSE_SIGNED],
    bus_half: control[CTL_BUS_HALF],
    sense_half: control[CTL_SENSE_HALF],
    src: acc_src_t'(control[CTL_SRC +: 2]),
    limit: limit_t'(control[CTL_LIMIT +: 2])
  };

  // Raw 16-bit conversions are placed into 17-bit signed carriers
  wire logic [RESULT_W-1:0] raw_bus = sample_reg[RESULT_W-1:0];
  wire logic [RESULT_W-1:0] raw_sense = sample_reg[SMP_SENSE +: RESULT_W];
  wire logic signed [SAMPLE_W-1:0] bus_17 = ctl.bus_signed ?
    (ctl.bus_half ? {raw_bus[RESULT_W-1], raw_bus} : {raw_bus, 1'b0}) :
    {1'b0, raw_bus};
  wire logic signed [SAMPLE_W-1:0] sense_17 = ctl.sense_signed ?
    (ctl.sense_half ? {raw_sense[RESULT_W-1], raw_sense} : {raw_sense, 1'b0}) :
    {1'b0, raw_sense};
  wire sample_pair_t pair = '{bus: bus_17, sense: sense_17};

  // Readable results: unsigned low bits or truncated signed top bits
  wire logic [RESULT_W-1:0] next_bus_read = ctl.bus_signed ?
    bus_17[SAMPLE_W-1 -: RESULT_W] : bus_17[RESULT_W-1:0];
  wire logic [RESULT_W-1:0] next_sense_read = ctl.sense_signed ?
    sense_17[SAMPLE_W-1 -: RESULT_W] : sense_17[RESULT_W-1:0];
  wire logic bipolar = ctl.bus_signed | ctl.sense_signed;
  wire logic [4:0] fs_log2 = bipolar ? FS_BIPOLAR_LOG2 : FS_UNIPOLAR_LOG2;

  // Effective rate: slow pin forces 8 SPS; scaling only in adaptive mode
  wire rate_t eff_rate = slow_level ? RATE_8 : ctl.rate;
  wire logic [2:0] next_shift = ctl.adaptive_off ? 3'h0 :
    (eff_rate == RATE_8) ? 3'(MAX_SHIFT) :
    (eff_rate == RATE_64) ? 3'h4 :
    (eff_rate == RATE_256) ? 3'h2 : 3'h0;
  wire logic [COUNT_W-1:0] next_inc = COUNT_W'(1) << next_shift;

  logic dp_valid;
  logic signed [ACC_W-1:0] dp_addend;

  energy_datapath energy_datapath_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .in_valid(sample_strobe),
    .in_pair(pair),
    .src(ctl.src),
    .shift(next_shift),
    .out_valid(dp_valid),
    .addend(dp_addend)
  );

  // Saturating add, detected by sign overflow
  wire logic signed [ACC_W-1:0] raw_sum = energy_accumulator + dp_addend;
  wire logic pos_ovf = !energy_accumulator[ACC_W-1] && !dp_addend[ACC_W-1] && raw_sum[ACC_W-1];
  wire logic neg_ovf = energy_accumulator[ACC_W-1] && dp_addend[ACC_W-1] && !raw_sum[ACC_W-1];
  wire logic signed [ACC_W-1:0] next_acc = pos_ovf ? ACC_MAX :
    neg_ovf ? ACC_MIN : raw_sum;
  wire logic [COUNT_W-1:0] next_count = count + pend_inc;

  // Fullness tests on magnitude of accumulator and on count
  wire logic [ACC_W-2:0] acc_mag = energy_accumulator[ACC_W-1] ?
    ~energy_accumulator[ACC_W-2:0] : energy_accumulator[ACC_W-2:0];
  wire logic [1:0] acc_top = acc_mag[ACC_W-2 -: 2];
  wire logic [3:0] acc_top4 = acc_mag[ACC_W-2 -: 4];
  wire logic [1:0] cnt_top = count[COUNT_W-1 -: 2];
  wire logic [3:0] cnt_top4 = count[COUNT_W-1 -: 4];
  wire logic acc_full = (acc_mag == {(ACC_W-1){1'b1}});
  wire logic cnt_full = (count == {COUNT_W{1'b1}});
  wire logic acc_limit = (ctl.limit == LIM_FULL) ? acc_full :
    (ctl.limit == LIM_15_16) ? (acc_top4 == 4'hf) :
    (ctl.limit == LIM_7_8) ? (acc_top4[3:1] == 3'h7) : (acc_top == 2'h3);
  wire logic cnt_limit = (ctl.limit == LIM_FULL) ? cnt_full :
    (ctl.limit == LIM_15_16) ? (cnt_top4 == 4'hf) :
    (ctl.limit == LIM_7_8) ? (cnt_top4[3:1] == 3'h7) : (cnt_top == 2'h3);

  // Slow pin synchroniser and edge detect on agreeing stages
  wire logic slow_changed = (slow_sync[2] == slow_sync[1]) && (slow_sync[1] != slow_level);
  wire logic next_refresh = slow_changed && ctl.slow_refresh;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      slow_sync <= 3'h0;
      slow_level <= 1'b0;
      refresh_pulse <= 1'b0;
      refresh_seen <= 1'b0;
    end
    else if (clk_en)
    begin
      slow_sync <= {slow_sync[1:0], slow_pin};
      if (slow_changed)
        slow_level <= slow_sync[1];
      refresh_pulse <= next_refresh;
      if (next_refresh)
        refresh_seen <= 1'b1;
      else if (clear_hit)
        refresh_seen <= 1'b0;
    end
  end

  // AXI4-Lite write path: address and data taken independently
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [DATA_W-1:0] w_data;
  logic [3:0] w_strb;
  wire logic do_write = aw_held && w_held && !s_axi_bvalid;
  wire logic wr_ctl = do_write && (aw_addr == OFS_CONTROL);
  wire logic wr_smp = do_write && (aw_addr == OFS_SAMPLE);
  assign clear_hit = do_write && (aw_addr == OFS_CLEAR);
  wire logic wr_known = wr_ctl || wr_smp || clear_hit;
  wire logic aw_take = s_axi_awvalid && s_axi_awready;
  wire logic w_take = s_axi_wvalid && s_axi_wready;
  // Held state one edge ahead, so the ready outputs can come from flops
  wire logic next_aw_held = (aw_held || aw_take) && !do_write;
  wire logic next_w_held = (w_held || w_take) && !do_write;
  logic [DATA_W-1:0] strobed;
  always_comb
  begin
    strobed = wr_ctl ? control : sample_reg;
    for (int b = 0; b < 4; b++)
      if (w_strb[b])
        strobed[b*8 +: 8] = w_data[b*8 +: 8];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
    end
    else if (clk_en)
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      s_axi_awready <= !next_aw_held;
      s_axi_wready <= !next_w_held;
      if (aw_take)
        aw_addr <= s_axi_awaddr;
      if (w_take)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? AXI_OKAY : AXI_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Software registers and conversion strobe
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      control <= CONTROL_RESET;
      sample_reg <= '0;
      sample_strobe <= 1'b0;
    end
    else if (clk_en)
    begin
      sample_strobe <= wr_smp;
      if (wr_ctl)
        control <= strobed;
      if (wr_smp)
        sample_reg <= strobed;
    end
  end

  // Accumulator, counter and result registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      energy_accumulator <= '0;
      count <= '0;
      saturated <= 1'b0;
      pend_inc <= '0;
      bus_voltage_sample <= '0;
      sense_voltage_sample <= '0;
    end
    else if (clk_en)
    begin
      if (sample_strobe)
      begin
        pend_inc <= next_inc;
        bus_voltage_sample <= next_bus_read;
        sense_voltage_sample <= next_sense_read;
      end
      if (dp_valid)
      begin
        energy_accumulator <= next_acc;
        count <= next_count;
      end
      else if (clear_hit)
      begin
        energy_accumulator <= '0;
        count <= '0;
      end
      if (dp_valid && (pos_ovf || neg_ovf))
        saturated <= 1'b1;
      else if (clear_hit)
        saturated <= 1'b0;
    end
  end

  // AXI4-Lite read path
  logic [DATA_W-1:0] rd_mux;
  wire logic [DATA_W-1:0] status_word = {16'h0, 3'h0, fs_log2, 2'h0, slow_level,
    refresh_seen, saturated, cnt_limit, acc_limit, bipolar};
  wire logic [DATA_W-1:0] acc_hi = DATA_W'($signed(energy_accumulator[ACC_W-1:DATA_W]));
  wire logic rd_known = (s_axi_araddr == OFS_CONTROL) || (s_axi_araddr == OFS_SAMPLE) ||
    (s_axi_araddr == OFS_STATUS) || (s_axi_araddr == OFS_ACC_LO) ||
    (s_axi_araddr == OFS_ACC_HI) || (s_axi_araddr == OFS_COUNT) ||
    (s_axi_araddr == OFS_RESULTS) || (s_axi_araddr == OFS_CLEAR);
  always_comb
  begin
    case (s_axi_araddr)
      OFS_CONTROL: rd_mux = control;
      OFS_SAMPLE: rd_mux = sample_reg;
      OFS_STATUS: rd_mux = status_word;
      OFS_ACC_LO: rd_mux = energy_accumulator[DATA_W-1:0];
      OFS_ACC_HI: rd_mux = acc_hi;
      OFS_COUNT: rd_mux = count;
      OFS_RESULTS: rd_mux = {sense_voltage_sample, bus_voltage_sample};
      default: rd_mux = '0;
    endcase
  end
  wire logic ar_take = s_axi_arvalid && s_axi_arready;
  wire logic next_rvalid = ar_take || (s_axi_rvalid && !s_axi_rready);

  // Read answer; registered arready stays low while an answer waits
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= AXI_OKAY;
    end
    else if (clk_en)
    begin
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (ar_take)
      begin
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_known ? AXI_OKAY : AXI_SLVERR;
      end
    end
  end
endmodule
`default_nettype wire

// file: verification/energy_accumulator_chk.sv
`timescale 1ns/100ps
`default_nettype none
// Port-level checks on the register bus answers and the refresh output
module energy_accumulator_chk
  import energy_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic refresh_pulse
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Answers stay up with a steady payload until the master takes them
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer not held");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer not held");
  // Write answer two edges after both halves are taken, read answer one edge after
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready && clk_en |=> ##1 s_axi_bvalid) else $error("write answer late");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready && clk_en
    |=> s_axi_rvalid) else $error("read answer late");
  chk_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  // Reset clears answers, pulse and ready outputs
  chk_reset_quiet: assert property (disable iff (1'b0) !aresetn && clk_en
    |=> !s_axi_bvalid && !s_axi_rvalid && !refresh_pulse) else $error("reset left outputs");
  chk_reset_ready: assert property (disable iff (1'b0) !aresetn
    |=> !s_axi_awready && !s_axi_wready && !s_axi_arready) else $error("ready in reset");
  chk_pulse_single: assert property (refresh_pulse && clk_en |=> !refresh_pulse)
    else $error("refresh pulse too long");
  // Main scenarios reached
  cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == AXI_SLVERR);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (s_axi_rvalid && !s_axi_rready);
  cover property (refresh_pulse);
endmodule
bind energy_accumulator_top energy_accumulator_chk energy_accumulator_chk_i (
  .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .refresh_pulse(refresh_pulse)
);
`default_nettype wire

// file: verification/energy_host.sv
`timescale 1ns/100ps
`default_nettype none
// Register bus master in the host's place; the bench calls its tasks
module energy_host
  import energy_pkg::*;
(
  input wire logic aclk,
  input wire logic clk_en,
  output logic [ADDR_W-1:0] s_axi_awaddr = '0,
  output logic [2:0] s_axi_awprot,
  output logic s_axi_awvalid = 1'b0,
  input wire logic s_axi_awready,
  output logic [DATA_W-1:0] s_axi_wdata = '0,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid = 1'b0,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready = 1'b0,
  output logic [ADDR_W-1:0] s_axi_araddr = '0,
  output logic [2:0] s_axi_arprot,
  output logic s_axi_arvalid = 1'b0,
  input wire logic s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready = 1'b0
);
  // Protection and strobes are fixed
  assign s_axi_awprot = 3'h0;
  assign s_axi_arprot = 3'h0;
  assign s_axi_wstrb = 4'hf;
  // Offers address and data together, drops each once taken, then waits for the answer
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                    output logic [1:0] r);
    logic ad;
    logic dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready && clk_en) ad = 1'b1;
      if (s_axi_wready && clk_en) dd = 1'b1;
      s_axi_awvalid <= !ad;
      s_axi_wvalid <= !dd;
    end
    while (!(ad && dd));
    // Late bready makes the slave hold its answer for a while
    repeat (2) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!(s_axi_bvalid && clk_en));
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // Offers a read address, raises rready one edge after the answer appears, then takes the data
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!(s_axi_arready && clk_en));
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!(s_axi_rvalid && clk_en));
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: verification/power_energy_accumulator_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CK(a, b, m) begin checked++; if ((a) !== (b)) \
  begin n_fail++; $display("CHECK FAILED %0t %s", $time, m); end end
module power_energy_accumulator_bench
  import energy_pkg::*;
;
  logic aclk, aresetn, clk_en, slow_pin, refresh_pulse;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int n_fail = 0;
  int checked = 0;
  int seed = 64457;
  int cyc = 0;
  int pulses = 0;
  int exp_pulses = 0;
  longint eacc = 0;
  logic [31:0] ecnt = 32'h0;
  energy_accumulator_top energy_accumulator_top_i (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .slow_pin(slow_pin),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .refresh_pulse(refresh_pulse)
  );
  energy_host energy_host_i (
    .aclk(aclk), .clk_en(clk_en),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
  );
  // Clock at 10 MHz
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // Counts refresh pulses and cuts a hang short
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (refresh_pulse === 1'b1) pulses <= pulses + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      results();
    end
  end
  task automatic results();
    if (n_fail == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Raw 16-bit sample to the internal 17-bit signed form
  function automatic logic [16:0] ext(logic [15:0] r, logic sg, logic hf);
    if (!sg) return {1'b0, r};
    if (hf) return {r[15], r};
    return {r, 1'b0};
  endfunction
  // Adaptive shift: slow level acts as 8 SPS; count step is two to this power
  function automatic int shamt(logic [11:0] c, logic sl);
    return c[2] ? 0 : (sl ? 7 : (c[1:0] == 2'h0 ? 0 : 2 * c[1:0] + (c[1:0] == 2'h3)));
  endfunction
  function automatic longint addend(logic [16:0] vb, logic [16:0] vs, logic [11:0] c, logic sl);
    longint p;
    p = $signed(vs) * $signed(vb[16:3]);
    p = $signed(p[29:0]);
    if (c[9:8] == 2'h1) p = $signed(vs);
    if (c[9:8] == 2'h2) p = $signed(vb);
    return p <<< shamt(c, sl);
  endfunction
  // Sets mode and slow level, injects one sample, then checks results and totals
  task automatic step(logic [11:0] c, logic sl, logic [15:0] b, logic [15:0] s);
    logic [16:0] vb;
    logic [16:0] vs;
    logic bip;
    vb = ext(b, c[4], c[6]);
    vs = ext(s, c[5], c[7]);
    bip = c[4] | c[5];
    energy_host_i.wr(OFS_CONTROL, {20'h0, c}, rs);
    if (c[3] && sl !== slow_pin) exp_pulses++;
    slow_pin <= sl;
    repeat (8) @(posedge aclk);
    energy_host_i.wr(OFS_SAMPLE, {s, b}, rs);
    `CK(rs, AXI_OKAY, "sample write")
    repeat (4) @(posedge aclk);
    eacc += addend(vb, vs, c, sl);
    ecnt += 32'h1 << shamt(c, sl);
    energy_host_i.rd(OFS_RESULTS, rdat, rs);
    `CK(rdat, {c[5] ? vs[16:1] : vs[15:0], c[4] ? vb[16:1] : vb[15:0]}, "results")
    energy_host_i.rd(OFS_ACC_LO, rdat, rs);
    `CK(rdat, eacc[31:0], "acc low")
    energy_host_i.rd(OFS_ACC_HI, rdat, rs);
    `CK(rdat, eacc[63:32], "acc high")
    energy_host_i.rd(OFS_COUNT, rdat, rs);
    `CK(rdat, ecnt, "count")
    energy_host_i.rd(OFS_STATUS, rdat, rs);
    `CK({rdat[12:8], rdat[5], rdat[3:0]}, {bip ? 5'h1d : 5'h1e, sl, 3'h0, bip}, "status")
  endtask
  // Main sequence: defaults, refused accesses, corners, random mix, clear
  initial
  begin
    aresetn = 1'b0;
    clk_en = 1'b1;
    slow_pin = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    energy_host_i.rd(OFS_CONTROL, rdat, rs);
    `CK(rdat, CONTROL_RESET, "control reset")
    slow_pin <= 1'b1;
    repeat (8) @(posedge aclk);
    `CK(pulses, 0, "refresh off")
    energy_host_i.wr(6'h20, 32'h1, rs);
    `CK(rs, AXI_SLVERR, "unmapped write")
    energy_host_i.wr(OFS_STATUS, 32'h1, rs);
    `CK(rs, AXI_SLVERR, "status write")
    energy_host_i.rd(6'h3c, rdat, rs);
    `CK({rs, rdat}, {AXI_SLVERR, 32'h0}, "unmapped read")
    step(12'h000, 1'b1, 16'hffff, 16'hffff);
    step(12'h030, 1'b0, 16'h8000, 16'h8000);
    step(12'h031, 1'b0, 16'h7fff, 16'h8000);
    step(12'h0f2, 1'b0, 16'h8000, 16'h7fff);
    step(12'h13b, 1'b1, 16'h1234, 16'hfedc);
    step(12'h22c, 1'b0, 16'h8001, 16'h0042);
    step(12'h307, 1'b1, 16'h4000, 16'hc000);
    repeat (40)
      step(12'($random(seed)), 1'($random(seed)), 16'($random(seed)), 16'($random(seed)));
    `CK(pulses, exp_pulses, "refresh count")
    energy_host_i.wr(OFS_CLEAR, 32'h0, rs);
    repeat (2) @(posedge aclk);
    energy_host_i.rd(OFS_COUNT, rdat, rs);
    `CK(rdat, 32'h0, "clear")
    results();
  end
endmodule
`default_nettype wire
